// File: hw/mem_pkg.sv
// mem_pkg: register map, sizes and shape decoders for the memory pair
// assumes one 100 MHz clock and an AXI4-Lite master on the control port
package mem_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LG_LEVEL_OFS = 8'h08;
  localparam logic [7:0] SM_LEVEL_OFS = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int LG_WSHAPE_LSB = 0;
  localparam int LG_RSHAPE_LSB = 4;
  localparam int LG_FIFO_BIT = 8;
  localparam int LG_ROM_BIT = 9;
  localparam int SM_SHAPE_LSB = 12;
  localparam int SM_FIFO_BIT = 16;
  localparam int SM_OREG_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // storage sizes
  // ----------------------------------------------------------------
  // 128 rows of 576 bits is 72Kb; every large shape packs into it
  localparam int LG_ROWS = 128;
  localparam int LG_ROW_BITS = 576;
  localparam int LG_DATA_W = 512;
  localparam int LG_ADDR_W = 14;
  localparam int LG_CNT_W = 15;
  localparam int SM_ROWS = 16;
  localparam int SM_ROW_BITS = 144;
  localparam int SM_ADDR_W = 6;
  localparam int SM_CNT_W = 7;
  localparam int LR_LATENCY = 2;

  typedef struct packed {
    logic [9:0] stride;
    logic [9:0] width;
    logic [2:0] lg_slots;
  } shape_t;

  // ----------------------------------------------------------------
  // shape decoders
  // ----------------------------------------------------------------
  // unused codes fall back to the 144-bit shape, the same as code 0
  function automatic shape_t lg_shape(input logic [3:0] code);
    case (code)
      4'h1: lg_shape = '{10'd576, 10'd512, 3'd0};
      4'h2: lg_shape = '{10'd72, 10'd72, 3'd3};
      4'h3: lg_shape = '{10'd72, 10'd64, 3'd3};
      4'h4: lg_shape = '{10'd36, 10'd36, 3'd4};
      4'h5: lg_shape = '{10'd36, 10'd32, 3'd4};
      4'h6: lg_shape = '{10'd18, 10'd18, 3'd5};
      4'h7: lg_shape = '{10'd18, 10'd16, 3'd5};
      4'h8: lg_shape = '{10'd9, 10'd9, 3'd6};
      4'h9: lg_shape = '{10'd9, 10'd8, 3'd6};
      4'ha: lg_shape = '{10'd4, 10'd4, 3'd7};
      default: lg_shape = '{10'd144, 10'd144, 3'd2};
    endcase
  endfunction : lg_shape

  function automatic shape_t sm_shape(input logic [1:0] code);
    case (code)
      2'h1: sm_shape = '{10'd72, 10'd72, 3'd1};
      2'h2: sm_shape = '{10'd36, 10'd36, 3'd2};
      default: sm_shape = '{10'd144, 10'd144, 3'd0};
    endcase
  endfunction : sm_shape

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == CTRL_OFS) || (a == STATUS_OFS) ||
      (a == LG_LEVEL_OFS) || (a == SM_LEVEL_OFS);
  endfunction : reg_mapped
endpackage : mem_pkg

// File: hw/ram_row_store.sv
// ram_row_store: row-wide store with bit-masked write and registered read
// assumes one clock; caller forms rows, masks and lane offsets
module ram_row_store #(
  parameter int ROWS = 128,
  parameter int BITS = 576
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [$clog2(ROWS)-1:0] wr_row,
  input wire logic [BITS-1:0] wr_mask,
  input wire logic [BITS-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(ROWS)-1:0] rd_row,
  output logic [BITS-1:0] rd_data
);
  typedef struct packed {
    logic [ROWS-1:0][BITS-1:0] rows;
    logic [BITS-1:0] rd_data;
  } store_t;
  store_t st;
  store_t next_st;

  if (ROWS < 2 || BITS < 1) begin : g_check
    $error("ram_row_store: ROWS must be 2 or more and BITS 1 or more");
  end

  always_comb begin
    next_st = st;
    // read sees the old row when both touch it in one cycle
    if (rd_en) begin
      next_st.rd_data = st.rows[rd_row];
    end
    if (wr_en) begin
      next_st.rows[wr_row] = (st.rows[wr_row] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;

  a_read_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
endmodule : ram_row_store

// File: hw/memory_pair.sv
// memory_pair: large block memory and small local memory with FIFO modes
// assumes user logic on sys_clk for both ports, AXI4-Lite for control
module memory_pair
  import mem_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic lw_en,
  input wire logic [mem_pkg::LG_ADDR_W-1:0] lw_addr,
  input wire logic [mem_pkg::LG_DATA_W-1:0] lw_data,
  output logic lw_full,
  input wire logic lr_en,
  input wire logic [mem_pkg::LG_ADDR_W-1:0] lr_addr,
  output logic [mem_pkg::LG_DATA_W-1:0] lr_data,
  output logic lr_valid,
  output logic lr_empty,
  input wire logic sw_en,
  input wire logic [mem_pkg::SM_ADDR_W-1:0] sw_addr,
  input wire logic [mem_pkg::SM_ROW_BITS-1:0] sw_data,
  output logic sw_full,
  input wire logic sr_en,
  input wire logic [mem_pkg::SM_ADDR_W-1:0] sr_addr,
  output logic [mem_pkg::SM_ROW_BITS-1:0] sr_data,
  output logic sr_empty
);
  import mem_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [LG_ADDR_W-1:0] lg_wptr;
    logic [LG_ADDR_W-1:0] lg_rptr;
    logic [LG_CNT_W-1:0] lg_count;
    logic lr_stage;
    logic [9:0] lr_off;
    logic [9:0] lr_width;
    logic lr_valid;
    logic [LG_DATA_W-1:0] lr_data;
    logic [SM_ROWS-1:0][SM_ROW_BITS-1:0] sm_rows;
    logic [SM_ADDR_W-1:0] sm_wptr;
    logic [SM_ADDR_W-1:0] sm_rptr;
    logic [SM_CNT_W-1:0] sm_count;
    logic [SM_ROW_BITS-1:0] sr_q;
  } state_t;
  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // decode of control fields
  // ----------------------------------------------------------------
  logic lg_fifo, lg_rom, sm_fifo, sm_oreg;
  shape_t lg_ws, lg_rs, sm_ws;
  logic [LG_CNT_W-1:0] lg_depth;
  logic [SM_CNT_W-1:0] sm_depth;
  logic wr_take, rd_take, ctrl_wr;
  logic lw_take, lr_take, sw_take, sr_take;
  logic [LG_ADDR_W-1:0] lg_wa, lg_ra;
  logic [6:0] lg_wrow, lg_rrow, lg_wslot, lg_rslot;
  logic [9:0] lg_woff, lg_roff;
  logic [LG_ROW_BITS-1:0] lg_wmask, lg_wdata, lg_rd;
  logic [SM_ADDR_W-1:0] sm_wa, sm_ra;
  logic [3:0] sm_wrow, sm_rrow;
  logic [7:0] sm_woff, sm_roff;
  logic [SM_ROW_BITS-1:0] sm_wmask, sm_width_mask, sm_comb;

  assign lg_fifo = s.ctrl[LG_FIFO_BIT];
  assign lg_rom = s.ctrl[LG_ROM_BIT];
  assign sm_fifo = s.ctrl[SM_FIFO_BIT];
  assign sm_oreg = s.ctrl[SM_OREG_BIT];
  assign lg_ws = lg_shape(s.ctrl[LG_WSHAPE_LSB +: 4]);
  // the FIFO keeps one shape on both ports so its pointers agree
  assign lg_rs = lg_fifo ? lg_ws : lg_shape(s.ctrl[LG_RSHAPE_LSB +: 4]);
  assign sm_ws = sm_shape(s.ctrl[SM_SHAPE_LSB +: 2]);
  assign lg_depth = LG_CNT_W'(LG_ROWS << lg_ws.lg_slots);
  assign sm_depth = SM_CNT_W'(SM_ROWS << sm_ws.lg_slots);

  // ----------------------------------------------------------------
  // large memory ports
  // ----------------------------------------------------------------
  assign lw_full = lg_fifo && (s.lg_count == lg_depth);
  assign lr_empty = lg_fifo && (s.lg_count == '0);
  assign lw_take = lw_en && !lg_rom && !lw_full;
  assign lr_take = lr_en && !lr_empty;
  assign lg_wa = lg_fifo ? s.lg_wptr : lw_addr;
  assign lg_ra = lg_fifo ? s.lg_rptr : lr_addr;
  assign lg_wrow = 7'(lg_wa >> lg_ws.lg_slots);
  assign lg_rrow = 7'(lg_ra >> lg_rs.lg_slots);
  assign lg_wslot = 7'(lg_wa) & ((7'd1 << lg_ws.lg_slots) - 7'd1);
  assign lg_rslot = 7'(lg_ra) & ((7'd1 << lg_rs.lg_slots) - 7'd1);
  assign lg_woff = 10'(lg_wslot * lg_ws.stride);
  assign lg_roff = 10'(lg_rslot * lg_rs.stride);
  assign lg_wmask = ({LG_ROW_BITS{1'b1}} >> (10'(LG_ROW_BITS) - lg_ws.width)) << lg_woff;
  assign lg_wdata = LG_ROW_BITS'(lw_data) << lg_woff;

  ram_row_store #(.ROWS(LG_ROWS), .BITS(LG_ROW_BITS)) u_large_block_memory (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(lw_take),
    .wr_row(lg_wrow),
    .wr_mask(lg_wmask),
    .wr_data(lg_wdata),
    .rd_en(lr_take),
    .rd_row(lg_rrow),
    .rd_data(lg_rd)
  );

  // ----------------------------------------------------------------
  // small memory ports
  // ----------------------------------------------------------------
  assign sw_full = sm_fifo && (s.sm_count == sm_depth);
  assign sr_empty = sm_fifo && (s.sm_count == '0);
  assign sw_take = sw_en && !sw_full;
  assign sr_take = sr_en && sm_fifo && !sr_empty;
  assign sm_wa = sm_fifo ? s.sm_wptr : sw_addr;
  assign sm_ra = sm_fifo ? s.sm_rptr : sr_addr;
  assign sm_wrow = 4'(sm_wa >> sm_ws.lg_slots);
  assign sm_rrow = 4'(sm_ra >> sm_ws.lg_slots);
  assign sm_woff = 8'((2'(sm_wa) & ((2'd1 << sm_ws.lg_slots) - 2'd1)) * sm_ws.stride);
  assign sm_roff = 8'((2'(sm_ra) & ((2'd1 << sm_ws.lg_slots) - 2'd1)) * sm_ws.stride);
  assign sm_width_mask = {SM_ROW_BITS{1'b1}} >> (10'(SM_ROW_BITS) - sm_ws.width);
  assign sm_wmask = sm_width_mask << sm_woff;
  // combinational read path straight from the array
  assign sm_comb = SM_ROW_BITS'(s.sm_rows[sm_rrow] >> sm_roff) & sm_width_mask;
  assign sr_data = sm_oreg ? s.sr_q : sm_comb;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_take = awvalid && wvalid && !s.bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign rd_take = arvalid && !s.rvalid;
  assign arready = !s.rvalid;
  assign ctrl_wr = wr_take && (awaddr == CTRL_OFS);
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign lr_valid = s.lr_valid;
  assign lr_data = s.lr_data;

  always_comb begin
    next_s = s;
    if (wr_take) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = reg_mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      next_s.bvalid = 1'b0;
    end
    if (ctrl_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb[i]) begin
          next_s.ctrl[8*i +: 8] = wdata[8*i +: 8];
        end
      end
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        CTRL_OFS: next_s.rdata = s.ctrl;
        STATUS_OFS: next_s.rdata = {28'h0, sr_empty, sw_full, lr_empty, lw_full};
        LG_LEVEL_OFS: next_s.rdata = 32'(s.lg_count);
        SM_LEVEL_OFS: next_s.rdata = 32'(s.sm_count);
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end else if (rready) begin
      next_s.rvalid = 1'b0;
    end
    // large read: row lands at edge 1, slot extracted at edge 2
    next_s.lr_stage = lr_take;
    next_s.lr_off = lg_roff;
    next_s.lr_width = lg_rs.width;
    next_s.lr_valid = s.lr_stage;
    if (s.lr_stage) begin
      next_s.lr_data = LG_DATA_W'(lg_rd >> s.lr_off) &
        ({LG_DATA_W{1'b1}} >> (10'(LG_DATA_W) - s.lr_width));
    end
    if (lg_fifo) begin
      if (lw_take) begin
        next_s.lg_wptr = (s.lg_wptr + 1'b1) & LG_ADDR_W'(lg_depth - 1'b1);
      end
      if (lr_take) begin
        next_s.lg_rptr = (s.lg_rptr + 1'b1) & LG_ADDR_W'(lg_depth - 1'b1);
      end
      next_s.lg_count = s.lg_count + LG_CNT_W'(lw_take) - LG_CNT_W'(lr_take);
    end
    if (sw_take) begin
      next_s.sm_rows[sm_wrow] = (s.sm_rows[sm_wrow] & ~sm_wmask) |
        ((SM_ROW_BITS'(sw_data) << sm_woff) & sm_wmask);
    end
    next_s.sr_q = sm_comb;
    if (sm_fifo) begin
      if (sw_take) begin
        next_s.sm_wptr = (s.sm_wptr + 1'b1) & SM_ADDR_W'(sm_depth - 1'b1);
      end
      if (sr_take) begin
        next_s.sm_rptr = (s.sm_rptr + 1'b1) & SM_ADDR_W'(sm_depth - 1'b1);
      end
      next_s.sm_count = s.sm_count + SM_CNT_W'(sw_take) - SM_CNT_W'(sr_take);
    end
    // reshaping under live pointers would corrupt them, so a control write flushes
    if (ctrl_wr) begin
      next_s.lg_wptr = '0;
      next_s.lg_rptr = '0;
      next_s.lg_count = '0;
      next_s.sm_wptr = '0;
      next_s.sm_rptr = '0;
      next_s.sm_count = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rom_no_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lg_rom |-> !lw_take)
    else $error("write accepted in read-only mode");
  a_large_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lw_take && !lg_fifo && s.ctrl[7:0] == 8'h00) ##1 (!lw_en && $stable(s.ctrl)) ##1
    (lr_take && lr_addr == $past(lw_addr, 2) && !lw_en && $stable(s.ctrl)) |->
    ##2 lr_data == LG_DATA_W'($past(lw_data[143:0], 4)))
    else $error("large memory did not return written word");
  a_read_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lr_take |-> ##2 lr_valid)
    else $error("large read valid not two cycles after request");
  a_large_depth: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s.lg_count <= lg_depth)
    else $error("large fifo level beyond shape depth");
  a_fifo_push: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lg_fifo && lw_take && !lr_take && !ctrl_wr |=> s.lg_count == $past(s.lg_count) + 1'b1)
    else $error("large fifo push did not raise the level");
  a_small_depth: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sm_fifo |-> s.sm_count <= sm_depth && (sw_full == (s.sm_count == sm_depth)))
    else $error("small fifo level beyond shape depth");
  a_small_comb: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sw_take && !sm_fifo && !sm_oreg && s.ctrl[13:12] == 2'h0) ##1
    (sr_addr == $past(sw_addr) && $stable(s.ctrl)) |-> sr_data == $past(sw_data))
    else $error("small memory combinational read missed written word");
  a_small_oreg: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sm_oreg ##1 sm_oreg |-> sr_data == $past(sm_comb))
    else $error("registered small read not one cycle late");
endmodule : memory_pair

// File: test/fabric_user.sv
// fabric_user: user logic model on the large memory's write and read ports
// assumes the bench calls put and get from one process, timed on sys_clk
module fabric_user
  import mem_pkg::*;
(
  input wire logic sys_clk,
  output logic lw_en,
  output logic [mem_pkg::LG_ADDR_W-1:0] lw_addr,
  output logic [mem_pkg::LG_DATA_W-1:0] lw_data,
  output logic lr_en,
  output logic [mem_pkg::LG_ADDR_W-1:0] lr_addr,
  input wire logic [mem_pkg::LG_DATA_W-1:0] lr_data,
  input wire logic lr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lw_en = 1'b0;
    lw_addr = '0;
    lw_data = '0;
    lr_en = 1'b0;
    lr_addr = '0;
  end
  // released lines carry the inverse so a stale value never passes for a hold
  task automatic put(input logic [13:0] a, input logic [511:0] d);
    @(posedge sys_clk);
    lw_en <= 1'b1;
    lw_addr <= a;
    lw_data <= d;
    @(posedge sys_clk);
    lw_en <= 1'b0;
    lw_addr <= ~a;
    lw_data <= ~d;
  endtask : put
  // lat counts edges from the request edge until valid shows
  task automatic get(input logic [13:0] a, output logic [511:0] d, output int lat);
    @(posedge sys_clk);
    lr_en <= 1'b1;
    lr_addr <= a;
    @(posedge sys_clk);
    lr_en <= 1'b0;
    lr_addr <= ~a;
    lat = 1;
    #1;
    while (lr_valid !== 1'b1 && lat < 10) begin
      @(posedge sys_clk);
      lat++;
      #1;
    end
    d = lr_data;
  endtask : get
endmodule : fabric_user

// File: test/tb_simple_dual_port_block_memory.sv
// tb_simple_dual_port_block_memory: self-checking bench for memory_pair
// assumes fabric_user drives the large ports; bench drives AXI and small ports
`define chk(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_simple_dual_port_block_memory;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = '0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sw_en = 1'b0;
  logic [5:0] sw_addr = '0;
  logic [143:0] sw_data = '0;
  logic sr_en = 1'b0;
  logic [5:0] sr_addr = '0;
  logic awready, wready, bvalid, arready, rvalid, lw_full, lr_empty, sw_full, sr_empty;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic lw_en, lr_en, lr_valid;
  logic [13:0] lw_addr, lr_addr;
  logic [511:0] lw_data, lr_data;
  logic [143:0] sr_data;
  int miscompares = 0;
  int samples_checked = 0;
  int wid[11] = '{144, 512, 72, 64, 36, 32, 18, 16, 9, 8, 4};
  int dep[11] = '{512, 128, 1024, 1024, 2048, 2048, 4096, 4096, 8192, 8192, 16384};

  always #5 sys_clk = ~sys_clk;

  memory_pair DUT (.sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lw_en(lw_en), .lw_addr(lw_addr), .lw_data(lw_data), .lw_full(lw_full), .lr_en(lr_en),
    .lr_addr(lr_addr), .lr_data(lr_data), .lr_valid(lr_valid), .lr_empty(lr_empty),
    .sw_en(sw_en), .sw_addr(sw_addr), .sw_data(sw_data), .sw_full(sw_full), .sr_en(sr_en),
    .sr_addr(sr_addr), .sr_data(sr_data), .sr_empty(sr_empty));
  fabric_user fab (.sys_clk(sys_clk), .lw_en(lw_en), .lw_addr(lw_addr), .lw_data(lw_data),
    .lr_en(lr_en), .lr_addr(lr_addr), .lr_data(lr_data), .lr_valid(lr_valid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [511:0] pat(input int i);
    for (int k = 0; k < 16; k++) begin
      pat[k*32 +: 32] = 32'(i * 32'h9e37_79b9) ^ 32'(k * 32'h0101_0101) ^ 32'h5a3c_96e1;
    end
  endfunction : pat
  function automatic logic [511:0] mk(input int w);
    mk = (512'h1 << w) - 512'h1;
  endfunction : mk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (awready !== 1'b1 && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic sw(input logic [5:0] a, input logic [143:0] d);
    @(posedge sys_clk);
    sw_en <= 1'b1;
    sw_addr <= a;
    sw_data <= d;
    @(posedge sys_clk);
    sw_en <= 1'b0;
    sw_data <= ~d;
  endtask : sw

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    logic [1:0] r;
    axr(CTRL_OFS, v, r);
    `chk(v, CTRL_RESET)
    axr(8'h10, v, r);
    `chk(r, RESP_SLVERR)
    axw(8'h10, 32'hffff_ffff, r);
    `chk(r, RESP_SLVERR)
  endtask : t_regs
  task automatic t_large;
    logic [511:0] d;
    logic [31:0] v;
    logic [1:0] r;
    int lat;
    for (int c = 0; c < 11; c++) begin
      axw(CTRL_OFS, 32'(c) | (32'(c) << 4), r);
      fab.put(14'h0, ~pat(c));
      fab.put(14'(dep[c] - 1), pat(c));
      fab.get(14'(dep[c] - 1), d, lat);
      `chk(d, pat(c) & mk(wid[c]))
      `chk(lat, 2)
    end
    axw(CTRL_OFS, 32'h0000_0032, r);
    fab.put(14'h7, pat(20));
    fab.get(14'h7, d, lat);
    `chk(d, pat(20) & mk(64))
    axw(CTRL_OFS, 32'h0, r);
    fab.put(14'h3, pat(30));
    axw(CTRL_OFS, 32'h0000_0200, r);
    fab.put(14'h3, pat(31));
    fab.get(14'h3, d, lat);
    `chk(d, pat(30) & mk(144))
    axr(CTRL_OFS, v, r);
    `chk(v, 32'h0000_0200)
  endtask : t_large
  task automatic t_fifo;
    logic [511:0] d;
    logic [31:0] v;
    logic [1:0] r;
    int lat;
    axw(CTRL_OFS, 32'h0001_2111, r);
    #1;
    `chk(lr_empty, 1'b1)
    `chk(sr_empty, 1'b1)
    for (int i = 0; i < 128; i++) fab.put(14'h0, pat(i));
    #1;
    `chk(lw_full, 1'b1)
    fab.put(14'h0, pat(999));
    // a push refused while full must leave the level at the shape depth
    axr(LG_LEVEL_OFS, v, r);
    `chk(v, 32'h0000_0080)
    for (int i = 0; i < 128; i++) begin
      fab.get(14'h0, d, lat);
      `chk(d, pat(i))
    end
    #1;
    `chk(lr_empty, 1'b1)
    for (int i = 0; i < 64; i++) begin
      d = pat(i);
      sw(6'h0, d[143:0]);
    end
    #1;
    `chk(sw_full, 1'b1)
    for (int i = 0; i < 64; i++) begin
      d = pat(i) & mk(36);
      #1;
      `chk(sr_data, d[143:0])
      @(posedge sys_clk);
      sr_en <= 1'b1;
      @(posedge sys_clk);
      sr_en <= 1'b0;
    end
    #1;
    `chk(sr_empty, 1'b1)
  endtask : t_fifo
  task automatic t_small;
    logic [511:0] d;
    logic [1:0] r;
    int sd[3] = '{16, 32, 64};
    for (int c = 0; c < 3; c++) begin
      axw(CTRL_OFS, 32'(c) << 12, r);
      d = pat(40 + c);
      sw(6'h0, ~d[143:0]);
      sw(6'(sd[c] - 1), d[143:0]);
      sr_addr <= 6'(sd[c] - 1);
      d = d & mk(144 >> c);
      #1;
      `chk(sr_data, d[143:0])
    end
    // output register on: new word shows one cycle after the combinational path
    axw(CTRL_OFS, 32'h0002_1000, r);
    d = pat(50) & mk(72);
    sw(6'h4, d[143:0]);
    sr_addr <= 6'h4;
    @(posedge sys_clk);
    sw(6'h4, ~d[143:0]);
    #1;
    `chk(sr_data, d[143:0])
    @(posedge sys_clk);
    #1;
    `chk(sr_data, ~d[143:0] & mk(72))
  endtask : t_small

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #500us;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_large();
    t_fifo();
    t_small();
    close_out();
  end
endmodule : tb_simple_dual_port_block_memory
